/* File: hw/zlk_pkg.sv */
// Purpose: shared constants for the zone lock and ephemeral key block
// Assumes: byte-wide lock values, 8-bit register address space
// Notes: lock bytes mirror configuration bytes 86 and 87
package zlk_pkg;
    localparam logic [7:0] ZLK_UNLOCKED = 8'h55;       // lock byte value meaning open
    localparam logic [7:0] ZLK_LOCKED = 8'h00;         // value written by lock command
    localparam logic [6:0] ZLK_CFG_LOCK_ADDR = 7'h57;  // config byte 87
    localparam logic [6:0] ZLK_DATA_LOCK_ADDR = 7'h56; // config byte 86
    localparam logic [6:0] ZLK_FIXED_LAST = 7'h0C;     // bytes 0..12 never writable
    // register offsets
    localparam logic [7:0] ZLK_REG_DATA_LOCK = 8'h56;
    localparam logic [7:0] ZLK_REG_CFG_LOCK = 8'h57;
    localparam logic [7:0] ZLK_REG_OTP_MODE = 8'h60;
    localparam logic [7:0] ZLK_REG_EKEY_STAT = 8'h61;
    localparam logic [7:0] ZLK_REG_LOCK_CMD = 8'h62;
    // otp permission modes
    localparam logic [7:0] ZLK_OTP_READ_ONLY = 8'hAA;
    localparam logic [7:0] ZLK_OTP_LEGACY = 8'h00;
    // zones
    typedef enum logic [1:0] {ZLK_ZONE_CFG, ZLK_ZONE_OTP, ZLK_ZONE_DATA} zlk_zone_t;
    // command classes seen by the ephemeral key logic
    typedef enum logic [2:0] {
        ZLK_CMD_NONCE, ZLK_CMD_GENDIGEST, ZLK_CMD_COMPARE_MAC, ZLK_CMD_OTHER
    } zlk_cmd_t;
    localparam int ZLK_KEY_W = 256;
    localparam int ZLK_TAG_W = 4;
    localparam logic [3:0] ZLK_OTP_WORD_HIDE = 4'h1; // legacy words 0 and 1 hidden
endpackage

/* File: hw/zlk_zone_lock.sv */
// Purpose: zone lock state, access permission check and ephemeral key register
// Assumes: single clock, async active-low reset models power-up
// Notes: key contents reach a port only as EKEY_XOR_BYTE; only status fields are register-readable
`timescale 1ns/10ps

module zlk_zone_lock
    import zlk_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // memory access check request
    input wire logic ACC_REQ,
    input wire zlk_pkg::zlk_zone_t ACC_ZONE,
    input wire logic ACC_WRITE,
    input wire logic ACC_WIDE,
    input wire logic [6:0] ACC_ADDR,
    input wire logic ACC_SLOT_WR_OK,
    output logic ACC_DONE,
    output logic ACC_GRANT,
    output logic ACC_ERROR,
    // command completion
    input wire logic CMD_DONE,
    input wire zlk_pkg::zlk_cmd_t CMD_KIND,
    input wire logic CMD_OK,
    input wire logic CMD_CRC_ERR,
    input wire logic CMD_COPY_OK,
    input wire logic [255:0] CMD_KEY,
    input wire logic [3:0] CMD_SLOT_TAG,
    input wire logic CMD_INPUT_ONLY,
    input wire logic CMD_FROM_SLOT,
    input wire logic CMD_VERIFY_ONLY,
    // power events, synchronised here
    input wire logic SLEEP,
    input wire logic BROWNOUT,
    input wire logic WATCHDOG,
    input wire logic TAMPER,
    // key path to crypto engine
    input wire logic KEY_USE,
    output logic KEY_USE_OK,
    output logic [7:0] EKEY_XOR_BYTE,
    input wire logic [4:0] KEY_BYTE_SEL,
    // otp blank bits
    output logic OTP_BLANK_FILL
);
    import zlk_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // lock bytes and mode
    logic [7:0] cfg_lock_reg;   // config zone lock byte
    logic [7:0] data_lock_reg;  // data and otp lock byte
    logic [7:0] otp_mode_reg;   // otp permission mode
    logic cfg_open;             // config still unlocked
    logic data_open;            // data/otp still unlocked

    assign cfg_open = (cfg_lock_reg == ZLK_UNLOCKED);
    assign data_open = (data_lock_reg == ZLK_UNLOCKED);

    // lock command: bit0 selects zone, only closing allowed
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_lock_reg <= ZLK_UNLOCKED;
            data_lock_reg <= ZLK_UNLOCKED;
        end else if (WR && ADDR == ZLK_REG_LOCK_CMD) begin
            // data lock needs config locked first
            if (!WDATA[0]) begin
                cfg_lock_reg <= ZLK_LOCKED;
            end else if (!cfg_open) begin
                data_lock_reg <= ZLK_LOCKED;
            end
        end
    end

    // mode byte lives in config zone, writable while it is open
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            otp_mode_reg <= ZLK_OTP_READ_ONLY;
        end else if (WR && ADDR == ZLK_REG_OTP_MODE && cfg_open) begin
            otp_mode_reg <= WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access permission check
    logic grant_next; // combinational verdict

    always_comb begin
        grant_next = 1'b0;
        case (ACC_ZONE)
            ZLK_ZONE_CFG: begin
                if (!ACC_WRITE) begin
                    grant_next = 1'b1;
                end else begin
                    // lock bytes reachable only through the lock command
                    grant_next = cfg_open && (ACC_ADDR > ZLK_FIXED_LAST)
                        && (ACC_ADDR != ZLK_CFG_LOCK_ADDR)
                        && (ACC_ADDR != ZLK_DATA_LOCK_ADDR);
                end
            end
            ZLK_ZONE_DATA: begin
                if (cfg_open) begin
                    grant_next = 1'b0;
                end else if (data_open) begin
                    grant_next = ACC_WRITE;
                end else begin
                    grant_next = !ACC_WRITE || ACC_SLOT_WR_OK;
                end
            end
            ZLK_ZONE_OTP: begin
                if (cfg_open) begin
                    grant_next = 1'b0;
                end else if (data_open) begin
                    grant_next = ACC_WRITE;
                end else if (otp_mode_reg == ZLK_OTP_READ_ONLY) begin
                    grant_next = !ACC_WRITE;
                end else if (otp_mode_reg == ZLK_OTP_LEGACY) begin
                    // word index in bits 5:2
                    grant_next = !ACC_WRITE && !ACC_WIDE
                        && (ACC_ADDR[5:2] > ZLK_OTP_WORD_HIDE);
                end else begin
                    grant_next = 1'b0; // unsupported modes refused
                end
            end
            default: grant_next = 1'b0;
        endcase
    end

    // verdict registered one cycle after request
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ACC_DONE <= 1'b0;
            ACC_GRANT <= 1'b0;
            ACC_ERROR <= 1'b0;
        end else begin
            ACC_DONE <= ACC_REQ;
            ACC_GRANT <= ACC_REQ && grant_next;
            ACC_ERROR <= ACC_REQ && !grant_next;
        end
    end

    assign OTP_BLANK_FILL = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // power event synchronisers
    logic [3:0] evt_meta_reg; // first stage
    logic [3:0] evt_sync_reg; // second stage
    logic wipe;               // any invalidating event

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            evt_meta_reg <= 4'h0;
            evt_sync_reg <= 4'h0;
        end else begin
            evt_meta_reg <= {SLEEP, BROWNOUT, WATCHDOG, TAMPER};
            evt_sync_reg <= evt_meta_reg;
        end
    end

    assign wipe = |evt_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // ephemeral key register
    logic [255:0] ekey_reg;     // key contents, out only via EKEY_XOR_BYTE
    logic [3:0] slot_tag_reg;   // slot that fed the digest
    logic origin_reg;           // randomness origin flag
    logic derived_reg;          // slot derived flag
    logic verify_reg;           // verify only flag
    logic valid_reg;            // key valid
    logic load_ok;              // successful nonce or digest
    logic is_keycmd;            // command is nonce or digest

    assign is_keycmd = (CMD_KIND == ZLK_CMD_NONCE) || (CMD_KIND == ZLK_CMD_GENDIGEST);
    // a crc failure leaves key and flags exactly as they were
    assign load_ok = CMD_DONE && is_keycmd && CMD_OK && !CMD_CRC_ERR;

    // contents and flags; retained across idle, sleep clears contents only
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ekey_reg <= '0;
            slot_tag_reg <= 4'h0;
            origin_reg <= 1'b0;
            derived_reg <= 1'b0;
            verify_reg <= 1'b0;
        end else if (evt_sync_reg[3]) begin
            ekey_reg <= '0;
        end else if (load_ok) begin
            ekey_reg <= CMD_KEY;
            slot_tag_reg <= CMD_SLOT_TAG;
            origin_reg <= CMD_INPUT_ONLY;
            derived_reg <= (CMD_KIND == ZLK_CMD_GENDIGEST) && CMD_FROM_SLOT;
            verify_reg <= (CMD_KIND == ZLK_CMD_GENDIGEST) && CMD_VERIFY_ONLY;
        end
    end

    // valid bit
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            valid_reg <= 1'b0;
        end else if (wipe) begin
            valid_reg <= 1'b0;
        end else if (CMD_DONE && !CMD_CRC_ERR) begin
            if (is_keycmd) begin
                valid_reg <= CMD_OK;
            end else if (CMD_KIND == ZLK_CMD_COMPARE_MAC) begin
                valid_reg <= valid_reg && CMD_COPY_OK;
            end else begin
                valid_reg <= 1'b0;
            end
        end
    end

    // keystream byte for protected reads/writes, gated by valid
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EKEY_XOR_BYTE <= 8'h00;
            KEY_USE_OK <= 1'b0;
        end else begin
            KEY_USE_OK <= KEY_USE && valid_reg;
            EKEY_XOR_BYTE <= (KEY_USE && valid_reg)
                ? ekey_reg[{KEY_BYTE_SEL, 3'b000} +: 8] : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, data one cycle later; key never readable
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                ZLK_REG_DATA_LOCK: RDATA <= data_lock_reg;
                ZLK_REG_CFG_LOCK: RDATA <= cfg_lock_reg;
                ZLK_REG_OTP_MODE: RDATA <= otp_mode_reg;
                ZLK_REG_EKEY_STAT: RDATA <= {valid_reg, verify_reg, derived_reg,
                    origin_reg, slot_tag_reg};
                default: RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule // zlk_zone_lock

/* File: testbench/zlk_zone_lock_chk.sv */
// Purpose: port assertions for the zone lock block
// Assumes: one clock, async active-low reset
// Notes: attached by bind from the bench top
`timescale 1ns/10ps
module zlk_zone_lock_chk
    import zlk_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] ADDR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic ACC_REQ,
    input wire zlk_pkg::zlk_zone_t ACC_ZONE,
    input wire logic ACC_WRITE,
    input wire logic ACC_DONE,
    input wire logic ACC_GRANT,
    input wire logic ACC_ERROR,
    input wire logic KEY_USE,
    input wire logic KEY_USE_OK,
    input wire logic OTP_BLANK_FILL
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    logic rd_cfg_reg; // config lock byte read last cycle
    logic shut_reg; // config lock seen closed since power-up
    ////////////////////////////////////////////////////////////////
    // remember a closed config lock so a reopen shows up
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_cfg_reg <= 1'b0;
            shut_reg <= 1'b0;
        end else begin
            rd_cfg_reg <= RD && ADDR == ZLK_REG_CFG_LOCK;
            if (rd_cfg_reg && RDATA != ZLK_UNLOCKED) shut_reg <= 1'b1;
        end
    end
    chk_req_done: assert property (ACC_REQ |=> ACC_DONE)
        else $error("access got no answer");
    chk_no_stray: assert property (!ACC_REQ |=> !ACC_DONE && !ACC_GRANT && !ACC_ERROR)
        else $error("answer without request");
    chk_one_verdict: assert property (ACC_DONE |-> ACC_GRANT ^ ACC_ERROR)
        else $error("grant and error not exclusive");
    chk_cfg_read: assert property (ACC_REQ && ACC_ZONE == ZLK_ZONE_CFG && !ACC_WRITE
        |=> ACC_GRANT)
        else $error("config read refused");
    chk_lock_stays: assert property (rd_cfg_reg && shut_reg |-> RDATA != ZLK_UNLOCKED)
        else $error("config lock reopened");
    chk_blank_ones: assert property (OTP_BLANK_FILL)
        else $error("blank otp fill not one");
    chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data outside a read");
    chk_key_idle: assert property (!KEY_USE |=> !KEY_USE_OK)
        else $error("key ok without use");
    cover property (ACC_DONE && ACC_ERROR);
    cover property (ACC_DONE && ACC_GRANT);
    cover property (KEY_USE_OK);
endmodule // zlk_zone_lock_chk

/* File: testbench/zlk_host_model.sv */
// Purpose: host side model issuing command completions
// Assumes: bench pulses go for one cycle with ctl set
// Notes: fields toggle while idle so only done-time values count
`timescale 1ns/10ps
module zlk_host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [12:0] ctl,
    output logic cmd_done,
    output logic [12:0] fld,
    output logic [255:0] key
);
    // done pulse one cycle after go, fields held only then
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_done <= 1'b0;
            fld <= 13'h0000;
        end else begin
            cmd_done <= go;
            fld <= go ? ctl : ~fld;
        end
    end
    assign key = {32{fld[7:0]}}; // key pattern follows the fields
endmodule // zlk_host_model

/* File: testbench/tb_zlk_zone_lock.sv */
// Purpose: self-checking bench for the zone lock block
// Assumes: 100 MHz clock, reset held five cycles
// Notes: lock flow run twice, once per otp mode
`timescale 1ns/10ps
module tb_zlk_zone_lock;
    import zlk_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, req = 0, aw = 0, wide = 0, kuse = 0, go = 0;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [6:0] aa = 0;
    zlk_zone_t zone = ZLK_ZONE_CFG;
    logic [12:0] ctl = 0, fld;
    logic [3:0] ev = 0; // sleep, brownout, watchdog, tamper
    logic [255:0] key;
    logic done, grant, err, cdone, kok, obf;
    logic slot_ok = 1'b1; // slot config allows write
    logic [7:0] xb; // keystream byte seen
    int errors = 0, total_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    zlk_host_model u_zlk_host_model (.clk(clk), .rst_n(rst_n), .go(go), .ctl(ctl),
        .cmd_done(cdone), .fld(fld), .key(key));
    zlk_zone_lock u_zlk_zone_lock (.REF_CLK(clk), .ARST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .ACC_REQ(req), .ACC_ZONE(zone), .ACC_WRITE(aw),
        .ACC_WIDE(wide), .ACC_ADDR(aa), .ACC_SLOT_WR_OK(slot_ok), .ACC_DONE(done),
        .ACC_GRANT(grant), .ACC_ERROR(err), .CMD_DONE(cdone), .CMD_KIND(zlk_cmd_t'(fld[12:10])),
        .CMD_OK(fld[9]), .CMD_CRC_ERR(fld[8]), .CMD_COPY_OK(fld[7]), .CMD_KEY(key),
        .CMD_SLOT_TAG(fld[6:3]), .CMD_INPUT_ONLY(fld[2]), .CMD_FROM_SLOT(fld[1]),
        .CMD_VERIFY_ONLY(fld[0]), .SLEEP(ev[0]), .BROWNOUT(ev[1]), .WATCHDOG(ev[2]),
        .TAMPER(ev[3]), .KEY_USE(kuse), .KEY_USE_OK(kok), .EKEY_XOR_BYTE(xb),
        .KEY_BYTE_SEL(5'h00), .OTP_BLANK_FILL(obf));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            test_done();
        end
    end
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read answer stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata & m, e);
    endtask
    task automatic acc(input zlk_zone_t z, input logic w, input logic wd, input logic [6:0] a,
        input logic g);
        @(posedge clk);
        req <= 1'b1;
        zone <= z;
        aw <= w;
        wide <= wd;
        aa <= a;
        @(posedge clk);
        req <= 1'b0;
        #1 check({5'h00, done, grant, err}, {5'h00, 1'b1, g, ~g});
    endtask
    task automatic cmd(input logic [12:0] c);
        @(posedge clk);
        go <= 1'b1;
        ctl <= c;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask
    task automatic use_key(input logic e, input logic [7:0] x);
        @(posedge clk);
        kuse <= 1'b1;
        @(posedge clk);
        kuse <= 1'b0;
        #1 check({7'h00, kok}, {7'h00, e});
        check(xb, x);
    endtask
    task automatic t_zones(input logic [7:0] mode);
        do_reset();
        reg_rd(8'h10, 8'h00);
        reg_rd(ZLK_REG_OTP_MODE, ZLK_OTP_READ_ONLY);
        acc(ZLK_ZONE_DATA, 1'b0, 1'b0, 7'h00, 1'b0);
        acc(ZLK_ZONE_OTP, 1'b1, 1'b0, 7'h00, 1'b0);
        acc(ZLK_ZONE_CFG, 1'b1, 1'b0, 7'h20, 1'b1);
        acc(ZLK_ZONE_CFG, 1'b1, 1'b0, 7'h0C, 1'b0);
        reg_wr(ZLK_REG_LOCK_CMD, 8'h01);
        reg_rd(ZLK_REG_DATA_LOCK, ZLK_UNLOCKED);
        reg_wr(ZLK_REG_OTP_MODE, mode);
        reg_wr(ZLK_REG_LOCK_CMD, 8'h00);
        reg_rd(ZLK_REG_CFG_LOCK, ZLK_LOCKED);
        reg_wr(ZLK_REG_CFG_LOCK, ZLK_UNLOCKED);
        reg_rd(ZLK_REG_CFG_LOCK, ZLK_LOCKED);
        reg_wr(ZLK_REG_OTP_MODE, ~mode);
        reg_rd(ZLK_REG_OTP_MODE, mode);
        acc(ZLK_ZONE_CFG, 1'b1, 1'b0, 7'h20, 1'b0);
        acc(ZLK_ZONE_DATA, 1'b0, 1'b0, 7'h00, 1'b0);
        acc(ZLK_ZONE_DATA, 1'b1, 1'b0, 7'h00, 1'b1);
        acc(ZLK_ZONE_OTP, 1'b1, 1'b1, 7'h00, 1'b1);
        acc(ZLK_ZONE_OTP, 1'b0, 1'b0, 7'h3C, 1'b0);
        reg_wr(ZLK_REG_LOCK_CMD, 8'h01);
        reg_rd(ZLK_REG_DATA_LOCK, ZLK_LOCKED);
        acc(ZLK_ZONE_DATA, 1'b0, 1'b1, 7'h00, 1'b1);
        slot_ok <= 1'b0;
        acc(ZLK_ZONE_DATA, 1'b1, 1'b0, 7'h00, 1'b0);
        slot_ok <= 1'b1;
        acc(ZLK_ZONE_DATA, 1'b1, 1'b0, 7'h00, 1'b1);
        check({7'h00, obf}, 8'h01);
        acc(ZLK_ZONE_OTP, 1'b1, 1'b0, 7'h3C, 1'b0);
        acc(ZLK_ZONE_OTP, 1'b0, 1'b0, 7'h04, mode == ZLK_OTP_READ_ONLY);
        acc(ZLK_ZONE_OTP, 1'b0, 1'b1, 7'h20, mode == ZLK_OTP_READ_ONLY);
        acc(ZLK_ZONE_OTP, 1'b0, 1'b0, 7'h08, 1'b1);
        $display("%m done");
    endtask
    task automatic t_key();
        use_key(1'b0, 8'h00);
        cmd(13'h022C);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h95);
        use_key(1'b1, 8'h2C);
        cmd(13'h0653);
        reg_rd(ZLK_REG_EKEY_STAT, 8'hEA);
        cmd(13'h0D00);
        reg_rd(ZLK_REG_EKEY_STAT, 8'hEA);
        cmd(13'h0E00);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h00, 8'h80);
        cmd(13'h022C);
        cmd(13'h0A80);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h80, 8'h80);
        cmd(13'h0A00);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h00, 8'h80);
        cmd(13'h0653);
        cmd(13'h022C);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h95);
        cmd(13'h0000);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h00, 8'h80);
        cmd(13'h022C);
        repeat (20) @(posedge clk);
        reg_rd(ZLK_REG_EKEY_STAT, 8'h95);
        for (int i = 0; i < 4; i++) begin
            cmd(13'h0653);
            ev <= 4'(1 << i);
            repeat (6) @(posedge clk);
            ev <= 4'h0;
            repeat (4) @(posedge clk);
            reg_rd(ZLK_REG_EKEY_STAT, 8'h00, 8'h80);
        end
        $display("%m done");
    endtask
    initial begin
        t_zones(ZLK_OTP_READ_ONLY);
        t_zones(ZLK_OTP_LEGACY);
        t_key();
        test_done();
    end
endmodule // tb_zlk_zone_lock
bind zlk_zone_lock zlk_zone_lock_chk u_zlk_zone_lock_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .ACC_REQ(ACC_REQ), .ACC_ZONE(ACC_ZONE),
    .ACC_WRITE(ACC_WRITE), .ACC_DONE(ACC_DONE), .ACC_GRANT(ACC_GRANT), .ACC_ERROR(ACC_ERROR),
    .KEY_USE(KEY_USE), .KEY_USE_OK(KEY_USE_OK), .OTP_BLANK_FILL(OTP_BLANK_FILL));
